// ---- shared/cdec_consts.svh ----
// command decoder constants: encodings, field positions, burst figures
// assumes inclusion by the package, the decoder and the bench
`ifndef CDEC_CONSTS_SVH
`define CDEC_CONSTS_SVH
`define CDEC_OP_MPC      5'h00
`define CDEC_OP_PRE      5'h10
`define CDEC_OP_REF      5'h08
`define CDEC_OP_SRE      5'h18
`define CDEC_OP_WR1      5'h04
`define CDEC_OP_SRX      5'h14
`define CDEC_OP_MWR1     5'h0C
`define CDEC_OP_RSV0     5'h1C
`define CDEC_OP_RD1      5'h02
`define CDEC_OP_CAS2     5'h12
`define CDEC_OP_RSV1     5'h0A
`define CDEC_OP_RSV2     5'h1A
`define CDEC_OP_MRW1     5'h06
`define CDEC_OP_MRW2     5'h16
`define CDEC_OP_MRR1     5'h0E
`define CDEC_OP_RSV3     5'h1E
`define CDEC_FLAG_BIT    5
`define CDEC_BURST_SHORT 6'h10
`define CDEC_BURST_LONG  6'h20
`define CDEC_MPC_FIFO_LO 7'h41
`define CDEC_MPC_FIFO_HI 7'h47
`endif

// ---- shared/cdec_pkg.sv ----
// types shared by the command decoder
// assumes cdec_consts.svh sits beside it
`include "cdec_consts.svh"
package cdec_pkg;
  typedef enum logic [3:0] {
    CMD_NONE, CMD_MPC, CMD_PRE, CMD_REF, CMD_SRE, CMD_SRX, CMD_WR,
    CMD_MWR, CMD_RD, CMD_MRW, CMD_MRR, CMD_ACT, CMD_ILLEGAL
  } cdec_cmd_type;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SECOND, ST_WAIT_CAS, ST_WAIT_ACT2, ST_WAIT_MRW2
  } cdec_state_type;
  typedef struct packed {
    cdec_cmd_type cmd;
    logic [2:0]   bank;
    logic         all_bank_flag;
    logic         auto_close_flag;
    logic [5:0]   burst;
    logic [9:0]   column;
    logic [15:0]  row;
    logic [5:0]   mode_addr;
    logic [7:0]   operand;
  } cdec_result_type;
  typedef struct packed {
    logic            cs_s1;
    logic [5:0]      ca_s1;
    logic            cs;
    logic [5:0]      ca;
    cdec_state_type  st;
    logic [4:0]      first_op;
    logic            first_flag;
    logic [5:0]      first_ca2;
    cdec_result_type pend;
    logic            valid;
    cdec_result_type res;
    logic            seq_err;
  } cdec_state_all_type;
endpackage

// ---- logic/cdec_decoder.sv ----
// two-cycle command decoder for a low-power dram channel
// assumes CLK_I is the command clock and cs/ca pins arrive unsynchronised
//
// Operation
// - commands span two cycles, identified from first-edge chip select and lines
// - chip select low on first edge is deselect; lines ignored
// - multi-purpose: lines 0-4 low, line 5 operand bit 6, then bits 0-5
// - precharge: first cycle code, line 5 all-bank, second cycle bank
// - refresh: first cycle code, line 5 all-bank, second cycle bank
// - three-bit bank selects target; all-bank flag overrides bank address
// - masked write uses burst of 16; line 5 low first cycle
// - auto-close flag closes bank after the access completes
// - burst flag chooses 32 or 16 beats when on-the-fly enabled
// - column second half: line 5 column bit 8, then bits 2-7
// - column bits 1 and 0 are zero for column second halves
`timescale 1ns/1ps
`include "cdec_consts.svh"
module cdec_decoder (
  input  wire logic                     CLK_I,        // command clock
  input  wire logic                     RST_I,        // async reset, high
  input  wire logic                     CE_I,         // clock enable
  input  wire logic                     CS_I,         // chip select pin
  input  wire logic [5:0]               CA_I,         // command/address pins
  input  wire logic                     OTF_EN_I,     // on-the-fly burst enable
  input  wire logic                     BURST_CFG_I,  // fixed burst: 1 = 32
  output logic                          VALID_O,      // decoded command pulse
  output cdec_pkg::cdec_result_type     RESULT_O,     // decoded command
  output logic                          SEQ_ERR_O     // sequence error pulse
);
  cdec_pkg::cdec_state_all_type r;
  cdec_pkg::cdec_state_all_type next_r;
  cdec_pkg::cdec_result_type    d;
  logic [4:0] op;

  assign op = r.ca[4:0];

  always_comb begin
    next_r         = r;
    d              = '0;
    d.cmd          = cdec_pkg::CMD_NONE;
    next_r.cs_s1   = CS_I;
    next_r.ca_s1   = CA_I;
    next_r.cs      = r.cs_s1;
    next_r.ca      = r.ca_s1;
    next_r.valid   = 1'b0;
    next_r.seq_err = 1'b0;
    unique case (r.st)
      cdec_pkg::ST_IDLE, cdec_pkg::ST_WAIT_CAS,
      cdec_pkg::ST_WAIT_ACT2, cdec_pkg::ST_WAIT_MRW2: begin
        if (r.cs) begin
          next_r.first_op   = op;
          next_r.first_flag = r.ca[`CDEC_FLAG_BIT];
          next_r.st         = cdec_pkg::ST_SECOND;
        end else if (r.st != cdec_pkg::ST_IDLE) begin
          // deselect where a second part was owed breaks the pair
          next_r.seq_err = 1'b1;
          next_r.st      = cdec_pkg::ST_IDLE;
          next_r.pend    = '0;
        end
      end
      cdec_pkg::ST_SECOND: begin
        // second cycle: chip select ignored, ca carries operands
        next_r.st = cdec_pkg::ST_IDLE;
        d         = r.pend;
        if (r.first_op[1:0] == 2'b11) begin
          // activate second part
          if (r.first_op[1] && !r.pend.row[0] && r.pend.cmd == cdec_pkg::CMD_ACT) begin
            d.row[9:0] = {r.first_flag, r.first_op[4:2], r.ca};
            next_r.valid = 1'b1;
          end else begin
            next_r.seq_err = 1'b1;
          end
          next_r.pend = '0;
        end else if (r.first_op[1:0] == 2'b01) begin
          // activate first part
          if (r.pend.cmd == cdec_pkg::CMD_ACT) begin
            next_r.seq_err = 1'b1;
          end
          next_r.pend.cmd        = cdec_pkg::CMD_ACT;
          next_r.pend.bank       = r.ca[2:0];
          next_r.pend.row        = '0;
          next_r.pend.row[15:10] = {r.first_flag, r.first_op[4:2], r.ca[5:4]};
          next_r.st              = cdec_pkg::ST_WAIT_ACT2;
        end else begin
          next_r.pend = '0;
          unique case (r.first_op)
            `CDEC_OP_MPC: begin
              d.cmd     = cdec_pkg::CMD_MPC;
              d.operand = {1'b0, r.first_flag, r.ca};
              if (d.operand >= `CDEC_MPC_FIFO_LO && d.operand <= `CDEC_MPC_FIFO_HI) begin
                next_r.pend = d;
                next_r.st   = cdec_pkg::ST_WAIT_CAS;
              end else begin
                next_r.valid = 1'b1;
              end
            end
            `CDEC_OP_PRE, `CDEC_OP_REF: begin
              d.cmd           = (r.first_op == `CDEC_OP_PRE) ? cdec_pkg::CMD_PRE
                                                             : cdec_pkg::CMD_REF;
              d.all_bank_flag = r.first_flag;
              d.bank          = r.first_flag ? 3'h0 : r.ca[2:0];
              next_r.valid    = 1'b1;
            end
            `CDEC_OP_SRE, `CDEC_OP_SRX: begin
              d.cmd        = (r.first_op == `CDEC_OP_SRE) ? cdec_pkg::CMD_SRE
                                                          : cdec_pkg::CMD_SRX;
              next_r.valid = 1'b1;
            end
            `CDEC_OP_WR1, `CDEC_OP_MWR1, `CDEC_OP_RD1: begin
              d.cmd = (r.first_op == `CDEC_OP_WR1) ? cdec_pkg::CMD_WR :
                      (r.first_op == `CDEC_OP_RD1) ? cdec_pkg::CMD_RD : cdec_pkg::CMD_MWR;
              d.bank            = r.ca[2:0];
              d.column          = '0;
              d.column[9]       = r.ca[4];
              d.auto_close_flag = r.ca[5];
              if (r.first_op == `CDEC_OP_MWR1) begin
                d.burst = `CDEC_BURST_SHORT;
              end else if (OTF_EN_I) begin
                d.burst = r.first_flag ? `CDEC_BURST_LONG : `CDEC_BURST_SHORT;
              end else begin
                d.burst = BURST_CFG_I ? `CDEC_BURST_LONG : `CDEC_BURST_SHORT;
              end
              next_r.pend = d;
              next_r.st   = cdec_pkg::ST_WAIT_CAS;
            end
            `CDEC_OP_MRR1: begin
              d.cmd       = cdec_pkg::CMD_MRR;
              d.mode_addr = r.ca;
              next_r.pend = d;
              next_r.st   = cdec_pkg::ST_WAIT_CAS;
            end
            `CDEC_OP_MRW1: begin
              d.cmd        = cdec_pkg::CMD_MRW;
              d.mode_addr  = r.ca;
              d.operand[7] = r.first_flag;
              next_r.pend  = d;
              next_r.st    = cdec_pkg::ST_WAIT_MRW2;
            end
            `CDEC_OP_MRW2: begin
              if (r.pend.cmd == cdec_pkg::CMD_MRW && r.st == cdec_pkg::ST_SECOND) begin
                d.operand[6:0] = {r.first_flag, r.ca};
                next_r.valid   = 1'b1;
              end
              next_r.seq_err = (r.pend.cmd != cdec_pkg::CMD_MRW);
            end
            `CDEC_OP_CAS2: begin
              if (r.pend.cmd inside {cdec_pkg::CMD_WR, cdec_pkg::CMD_MWR, cdec_pkg::CMD_RD,
                                     cdec_pkg::CMD_MRR, cdec_pkg::CMD_MPC}) begin
                d.column[8:0] = {r.first_flag, r.ca, 2'b00};
                next_r.valid  = 1'b1;
              end else begin
                next_r.seq_err = 1'b1;
              end
            end
            default: begin
              // reserved codes: nothing latched, nothing issued
              d              = '0;
              next_r.seq_err = 1'b1;
            end
          endcase
        end
        if (r.pend.cmd != cdec_pkg::CMD_NONE && r.pend.cmd != cdec_pkg::CMD_ACT
            && r.first_op != `CDEC_OP_CAS2 && r.first_op != `CDEC_OP_MRW2) begin
          next_r.seq_err = 1'b1;
        end
        if (r.pend.cmd == cdec_pkg::CMD_ACT && r.first_op[1:0] != 2'b11
            && r.first_op[1:0] != 2'b01) begin
          next_r.seq_err = 1'b1;
        end
        if (next_r.valid) begin
          next_r.res = d;
        end
      end
      default: next_r.st = cdec_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      r <= '0;
    end else if (CE_I) begin
      r <= next_r;
    end
  end

  assign VALID_O   = r.valid;
  assign RESULT_O  = r.res;
  assign SEQ_ERR_O = r.seq_err;

  property p_cas_follows;
    @(posedge CLK_I) disable iff (RST_I)
      (CE_I && r.st == cdec_pkg::ST_SECOND && r.first_op == `CDEC_OP_CAS2
       && r.pend.cmd == cdec_pkg::CMD_RD) |=> VALID_O && RESULT_O.column[1:0] == 2'b00;
  endproperty
  a_cas_follows: assert property (p_cas_follows) else $error("column pair not issued");

  property p_deselect_idle;
    @(posedge CLK_I) disable iff (RST_I)
      (CE_I && r.st == cdec_pkg::ST_IDLE && !r.cs) |=> r.st == cdec_pkg::ST_IDLE;
  endproperty
  a_deselect_idle: assert property (p_deselect_idle) else $error("deselect left idle");

  property p_mwr_burst;
    @(posedge CLK_I) disable iff (RST_I)
      VALID_O && RESULT_O.cmd == cdec_pkg::CMD_MWR |-> RESULT_O.burst == `CDEC_BURST_SHORT;
  endproperty
  a_mwr_burst: assert property (p_mwr_burst) else $error("masked write burst wrong");

  property p_all_bank;
    @(posedge CLK_I) disable iff (RST_I)
      VALID_O && RESULT_O.all_bank_flag |-> RESULT_O.bank == 3'h0;
  endproperty
  a_all_bank: assert property (p_all_bank) else $error("bank kept with all-bank");

  sequence s_rsv_code;
    CE_I && r.st == cdec_pkg::ST_SECOND && r.first_op inside
      {`CDEC_OP_RSV0, `CDEC_OP_RSV1, `CDEC_OP_RSV2, `CDEC_OP_RSV3};
  endsequence
  property p_rsv_quiet;
    @(posedge CLK_I) disable iff (RST_I)
      s_rsv_code |=> SEQ_ERR_O && !VALID_O;
  endproperty
  a_rsv_quiet: assert property (p_rsv_quiet) else $error("reserved code accepted");

  sequence s_act_again;
    CE_I && r.st == cdec_pkg::ST_SECOND && r.first_op[1:0] == 2'b01
      && r.pend.cmd == cdec_pkg::CMD_ACT;
  endsequence
  property p_act_twice;
    @(posedge CLK_I) disable iff (RST_I)
      s_act_again |=> SEQ_ERR_O;
  endproperty
  a_act_twice: assert property (p_act_twice) else $error("second activate opener kept");

  sequence s_act_close;
    CE_I && r.st == cdec_pkg::ST_SECOND && r.first_op[1:0] == 2'b11
      && r.pend.cmd == cdec_pkg::CMD_ACT;
  endsequence
  property p_act_row;
    @(posedge CLK_I) disable iff (RST_I)
      s_act_close |=> VALID_O && RESULT_O.cmd == cdec_pkg::CMD_ACT
                      && RESULT_O.row[15:10] == $past(r.pend.row[15:10]);
  endproperty
  a_act_row: assert property (p_act_row) else $error("activate pair not issued");

  // mode write only completes when its two parts sit back to back
  sequence s_mrw_two;
    (CE_I && r.st == cdec_pkg::ST_SECOND && r.first_op == `CDEC_OP_MRW1) ##1 (CE_I && r.cs)
      ##1 (CE_I && r.st == cdec_pkg::ST_SECOND && r.first_op == `CDEC_OP_MRW2);
  endsequence
  property p_mrw_pair;
    @(posedge CLK_I) disable iff (RST_I)
      s_mrw_two |=> VALID_O && RESULT_O.cmd == cdec_pkg::CMD_MRW;
  endproperty
  a_mrw_pair: assert property (p_mrw_pair) else $error("mode write pair lost");

  sequence s_wr_two;
    (CE_I && r.st == cdec_pkg::ST_SECOND && r.first_op == `CDEC_OP_WR1) ##1 (CE_I && r.cs)
      ##1 (CE_I && r.st == cdec_pkg::ST_SECOND && r.first_op == `CDEC_OP_CAS2);
  endsequence
  property p_wr_pair;
    @(posedge CLK_I) disable iff (RST_I)
      s_wr_two |=> VALID_O && RESULT_O.cmd == cdec_pkg::CMD_WR;
  endproperty
  a_wr_pair: assert property (p_wr_pair) else $error("write pair lost");

  // a gap where a second part is owed must also drop the pending half
  sequence s_owed_gap;
    CE_I && !r.cs && r.st inside
      {cdec_pkg::ST_WAIT_CAS, cdec_pkg::ST_WAIT_ACT2, cdec_pkg::ST_WAIT_MRW2};
  endsequence
  property p_owed_gap;
    @(posedge CLK_I) disable iff (RST_I)
      s_owed_gap |=> SEQ_ERR_O && r.st == cdec_pkg::ST_IDLE && r.pend.cmd == cdec_pkg::CMD_NONE;
  endproperty
  a_owed_gap: assert property (p_owed_gap) else $error("broken pair not flagged");

  property p_mpc_operand;
    @(posedge CLK_I) disable iff (RST_I)
      (CE_I && r.st == cdec_pkg::ST_SECOND && r.first_op == `CDEC_OP_MPC && !r.first_flag)
      |=> VALID_O && RESULT_O.cmd == cdec_pkg::CMD_MPC
          && RESULT_O.operand == {2'b00, $past(r.ca)};
  endproperty
  a_mpc_operand: assert property (p_mpc_operand) else $error("multi-purpose operand wrong");

  property p_pre_decode;
    @(posedge CLK_I) disable iff (RST_I)
      (CE_I && r.st == cdec_pkg::ST_SECOND && r.first_op == `CDEC_OP_PRE)
      |=> VALID_O && RESULT_O.cmd == cdec_pkg::CMD_PRE
          && RESULT_O.all_bank_flag == $past(r.first_flag);
  endproperty
  a_pre_decode: assert property (p_pre_decode) else $error("precharge decode wrong");

  property p_burst_otf;
    @(posedge CLK_I) disable iff (RST_I)
      (CE_I && OTF_EN_I && r.st == cdec_pkg::ST_SECOND && r.first_op == `CDEC_OP_RD1)
      |=> r.pend.burst == ($past(r.first_flag) ? `CDEC_BURST_LONG : `CDEC_BURST_SHORT);
  endproperty
  a_burst_otf: assert property (p_burst_otf) else $error("on-the-fly burst wrong");
endmodule

// ---- dv/cdec_ctrl_model.sv ----
// controller model: drives chip select and command lines off the falling edge
// assumes the bench calls one task at a time, so pairs stay back to back
`timescale 1ns/1ps
module cdec_ctrl_model (
  input  wire logic       clk_i,  // command clock
  output logic            cs_o,   // chip select
  output logic [5:0]      ca_o    // command/address lines
);
  initial begin
    cs_o = 1'b0;
    ca_o = 6'h2A;
  end
  // lines are not held while idle: a stale value must not look valid
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clk_i);
      cs_o = 1'b0;
      ca_o = ~ca_o;
    end
  endtask
  // one two-cycle command, select high on the first cycle only
  task automatic cmd(input logic [5:0] c1, input logic [5:0] c2);
    @(negedge clk_i);
    cs_o = 1'b1;
    ca_o = c1;
    @(negedge clk_i);
    cs_o = 1'b0;
    ca_o = c2;
  endtask
endmodule

// ---- dv/cdec_decoder_test.sv ----
// self-checking bench for the command decoder
// assumes a 125 MHz clock and the controller model beside it
`timescale 1ns/1ps
`include "cdec_consts.svh"
module cdec_decoder_test;
  typedef struct packed {
    logic                      err;
    cdec_pkg::cdec_result_type res;
    cdec_pkg::cdec_result_type msk;
  } cdec_note_type;
  logic                      CLK_I, RST_I, CE_I, CS_I, OTF_EN_I, BURST_CFG_I;
  logic [5:0]                CA_I;
  logic                      VALID_O, SEQ_ERR_O;
  cdec_pkg::cdec_result_type RESULT_O;
  cdec_note_type             q[$];
  int                        n_fail, checks;
  cdec_decoder DUT (.CLK_I(CLK_I), .RST_I(RST_I), .CE_I(CE_I), .CS_I(CS_I), .CA_I(CA_I),
    .OTF_EN_I(OTF_EN_I), .BURST_CFG_I(BURST_CFG_I), .VALID_O(VALID_O),
    .RESULT_O(RESULT_O), .SEQ_ERR_O(SEQ_ERR_O));
  cdec_ctrl_model ctrl (.clk_i(CLK_I), .cs_o(CS_I), .ca_o(CA_I));
  initial begin
    CLK_I = 1'b0;
    forever #4 CLK_I = ~CLK_I;
  end
  task automatic fail(input string s);
    n_fail++;
    $display("[ERR] %0t %s", $time, s);
  endtask
  task automatic wrap_up();
    $display("checks %0d fails %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // mask picks the fields a command defines; cmd is always compared
  task automatic expect_cmd(input cdec_pkg::cdec_result_type r, m);
    q.push_back({1'b0, r, m});
  endtask
  task automatic expect_err();
    cdec_note_type n;
    n = '0;
    n.err = 1'b1;
    q.push_back(n);
  endtask
  task automatic cmp_res(input cdec_note_type n);
    checks++;
    if (n.err !== 1'b0 || RESULT_O.cmd !== n.res.cmd || (RESULT_O & n.msk) !== (n.res & n.msk))
      fail($sformatf("result %h want %h", RESULT_O, n.res));
  endtask
  task automatic cmp_err(input cdec_note_type n);
    checks++;
    if (n.err !== 1'b1) fail("sequence error not expected");
  endtask
  always @(negedge CLK_I) begin
    if (RST_I === 1'b0 && (VALID_O !== 1'b0 || SEQ_ERR_O !== 1'b0)) begin
      if (q.size() == 0) begin
        checks++;
        fail("output pulse with nothing pending");
      end else if (VALID_O === 1'b1) cmp_res(q.pop_front());
      else cmp_err(q.pop_front());
    end
  end
  task automatic done(input string s);
    for (int k = 0; k < 40 && q.size() != 0; k++) @(negedge CLK_I);
    if (q.size() != 0) begin
      fail("result never came");
      wrap_up();
    end
    ctrl.idle(4);
    $display("test %s done", s);
  endtask
  initial begin
    for (int t = 0; t < 20000; t++) @(negedge CLK_I);
    fail("timeout");
    wrap_up();
  end
  initial begin
    cdec_pkg::cdec_result_type r, m;
    logic [2:0]                ba;
    logic [7:0]                c;
    logic [15:0]               w;
    logic                      ab, ap, bl;
    n_fail = 0;
    checks = 0;
    {RST_I, CE_I, OTF_EN_I, BURST_CFG_I} = 4'b1110;
    void'($urandom(32'hc2091513));
    repeat (16) @(negedge CLK_I);
    RST_I = 1'b0;
    for (int i = 0; i < 4; i++) begin
      {ba, ab} = {3'($urandom), i[0]};
      r = '0;
      m = '0;
      r.cmd = i[1] ? cdec_pkg::CMD_REF : cdec_pkg::CMD_PRE;
      {r.all_bank_flag, m.all_bank_flag, r.bank, m.bank} = {ab, 1'b1, ba, {3{~ab}}};
      expect_cmd(r, m);
      ctrl.cmd({ab, i[1] ? `CDEC_OP_REF : `CDEC_OP_PRE}, {3'($urandom), ba});
    end
    done("bank");
    // on-the-fly first, then the fixed burst setting
    for (int i = 0; i < 8; i++) begin
      OTF_EN_I = (i < 6);
      BURST_CFG_I = i[0];
      {ba, c, ap, bl} = {3'($urandom), 8'($urandom), 1'($urandom), 1'($urandom)};
      if (i % 3 == 1 && i < 6) bl = 1'b0;
      if (i % 3 != 2 && i < 6) c[1:0] = 2'b00;
      r = '0;
      m = '0;
      r.cmd = (i % 3 == 0 && i < 6) ? cdec_pkg::CMD_WR :
              (i % 3 == 1 && i < 6) ? cdec_pkg::CMD_MWR : cdec_pkg::CMD_RD;
      r.burst = (i < 6 ? bl : BURST_CFG_I) ? `CDEC_BURST_LONG : `CDEC_BURST_SHORT;
      {r.bank, r.auto_close_flag, r.column} = {ba, ap, c, 2'b00};
      {m.bank, m.auto_close_flag, m.burst, m.column} = '1;
      expect_cmd(r, m);
      ctrl.cmd({bl, r.cmd == cdec_pkg::CMD_WR ? `CDEC_OP_WR1 : r.cmd == cdec_pkg::CMD_MWR ?
               `CDEC_OP_MWR1 : `CDEC_OP_RD1}, {ap, c[7], 1'b0, ba});
      ctrl.cmd({c[6], `CDEC_OP_CAS2}, c[5:0]);
      // burst settings must not move before this pair is decoded
      ctrl.idle(2);
      if (i == 5) done("column");
    end
    done("burst");
    {w, ba} = {16'($urandom), 3'($urandom)};
    r = '0;
    m = '0;
    {r.cmd, r.operand, m.operand} = {cdec_pkg::CMD_MPC, 2'b00, w[5:0], 8'h7F};
    expect_cmd(r, m);
    ctrl.cmd({1'b0, `CDEC_OP_MPC}, w[5:0]);
    ctrl.idle(2);
    {r.cmd, r.mode_addr, r.operand, m.mode_addr, m.operand} =
      {cdec_pkg::CMD_MRW, w[13:8], w[7:0], 6'h3F, 8'hFF};
    expect_cmd(r, m);
    ctrl.cmd({w[7], `CDEC_OP_MRW1}, w[13:8]);
    ctrl.cmd({w[6], `CDEC_OP_MRW2}, w[5:0]);
    {r.cmd, m.operand} = {cdec_pkg::CMD_MRR, 8'h00};
    expect_cmd(r, m);
    ctrl.cmd({1'b0, `CDEC_OP_MRR1}, w[13:8]);
    ctrl.cmd({1'b0, `CDEC_OP_CAS2}, 6'h00);
    r = '0;
    m = '0;
    {r.cmd, r.row, r.bank, m.row, m.bank} = {cdec_pkg::CMD_ACT, w, ba, 16'hFFFF, 3'h7};
    expect_cmd(r, m);
    ctrl.cmd({w[15:12], 2'b01}, {w[11:10], 1'b0, ba});
    ctrl.cmd({w[9:6], 2'b11}, w[5:0]);
    done("mode and activate");
    for (int k = 0; k < 4; k++) begin
      expect_err();
      ctrl.cmd({1'b0, k == 0 ? `CDEC_OP_RSV0 : k == 1 ? `CDEC_OP_RSV1 :
               k == 2 ? `CDEC_OP_RSV2 : `CDEC_OP_RSV3}, 6'h15);
    end
    r = '0;
    r.cmd = cdec_pkg::CMD_SRE;
    expect_cmd(r, '0);
    ctrl.cmd({1'b0, `CDEC_OP_SRE}, 6'h00);
    r.cmd = cdec_pkg::CMD_SRX;
    expect_cmd(r, '0);
    ctrl.cmd({1'b0, `CDEC_OP_SRX}, 6'h00);
    expect_err();
    ctrl.cmd({1'b0, `CDEC_OP_RD1}, 6'h01);
    ctrl.idle(3);
    expect_err();
    ctrl.cmd(6'h01, 6'h02);
    ctrl.idle(3);
    expect_err();
    expect_err();
    ctrl.cmd(6'h01, 6'h02);
    ctrl.cmd(6'h05, 6'h03);
    ctrl.idle(3);
    done("refusals");
    // after illegal traffic the controller restarts the device
    @(negedge CLK_I);
    RST_I = 1'b1;
    repeat (2) @(negedge CLK_I);
    RST_I = 1'b0;
    r = '0;
    m = '0;
    {r.cmd, r.all_bank_flag, m.all_bank_flag} = {cdec_pkg::CMD_PRE, 1'b1, 1'b1};
    expect_cmd(r, m);
    ctrl.cmd({1'b1, `CDEC_OP_PRE}, 6'h00);
    done("restart");
    wrap_up();
  end
endmodule
